// File: shared/pio_pkg.sv
/*
 * constants, types and helpers shared by the parallel io port block.
 * assumes a 32-bit register bus with one aligned word per register.
 */
package pio_pkg;
    localparam int unsigned PIO_MAX_PINS = 32;
    localparam logic [31:0] PIO_ADDR_INPUT = 32'hfffc0000;
    localparam logic [31:0] PIO_ADDR_OUTPUT = 32'hfffc0004;
    localparam logic [31:0] PIO_ADDR_RSVD_A = 32'hfffc0008;
    localparam logic [31:0] PIO_ADDR_RSVD_B = 32'hfffc000c;
    localparam logic [31:0] PIO_ADDR_KIND = 32'hfffc0010;
    localparam logic [31:0] PIO_ADDR_SENSE = 32'hfffc0014;
    localparam logic [31:0] PIO_ADDR_ALLOW = 32'hfffc0018;
    localparam logic [31:0] PIO_ADDR_FLAGS = 32'hfffc001c;
    localparam logic [31:0] PIO_ADDR_EVT_STATUS = 32'hfffc0020;
    localparam logic [31:0] PIO_ADDR_EVT_MASK = 32'hfffc0024;
    localparam logic [31:0] PIO_REG_RESET = 32'h00000000;
    localparam logic [31:0] PIO_ALL_ONES = 32'hffffffff;
    // event status / mask layout
    localparam int unsigned PIO_EVT_W = 2;
    localparam int unsigned PIO_EVT_PIN = 0;
    localparam int unsigned PIO_EVT_BUSERR = 1;
    localparam logic [1:0] PIO_EVT_RESET = 2'h0;
    // trigger bit meanings
    localparam logic PIO_KIND_LEVEL = 1'b0;
    localparam logic PIO_KIND_EDGE = 1'b1;
    localparam logic PIO_SENSE_LOW = 1'b0;
    localparam logic PIO_SENSE_HIGH = 1'b1;
    localparam logic [1:0] PIO_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PIO_RD_IDLE = 2'b01,
        PIO_RD_RESP = 2'b10
    } pio_rd_e;

    // ones in the low n bits, the implemented pins
    function automatic logic [31:0] pio_pin_mask(input int unsigned n);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 32; i++) begin
            if (i < n) m[i] = 1'b1;
        end
        return m;
    endfunction : pio_pin_mask

    // byte-strobed update of a register word
    function automatic logic [31:0] pio_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction : pio_merge
endpackage : pio_pkg

// File: shared/pio_trig_if.sv
/*
 * carrier between the register core and the trigger detector.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface pio_trig_if;
    logic [31:0] pins; // synchronised input pins
    logic [31:0] kind; // 0 level, 1 edge
    logic [31:0] sense; // 0 low/falling, 1 high/rising
    logic [31:0] allow; // per-pin enable
    logic [31:0] fire; // per-pin trigger fired this cycle
    modport ctrl (output pins, output kind, output sense, output allow, input fire);
    modport trig (input pins, input kind, input sense, input allow, output fire);
endinterface : pio_trig_if

// File: rtl/pio_sync.sv
/*
 * two flip-flop synchroniser for the parallel input pins.
 * assumes the pins are asynchronous to aclk; bits are not coherent as a word.
 */
`timescale 1ns/1ps
module pio_sync
    import pio_pkg::*;
(
    input wire logic aclk, // processor clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [31:0] async_in, // raw pins
    output logic [31:0] sync_out // pins after two flops
);
    typedef struct packed {
        logic [31:0] stage1;
        logic [31:0] stage2;
    } pio_sync_s;

    pio_sync_s s_q;
    pio_sync_s s_d;

    // stage1 feeds only stage2, never any logic
    always_comb begin
        s_d = s_q;
        s_d.stage1 = async_in;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stage2;
endmodule : pio_sync

// File: rtl/pio_trig.sv
/*
 * per-pin level and edge trigger detector.
 * assumes synchronised pins and configuration from the register core.
 */
`timescale 1ns/1ps
module pio_trig
    import pio_pkg::*;
(
    input wire logic aclk, // processor clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable
    pio_trig_if.trig tif // pins, configuration and fire flags
);
    typedef struct packed {
        logic [31:0] prev;
        logic prev_valid;
    } pio_trig_s;

    pio_trig_s s_q;
    pio_trig_s s_d;
    logic [31:0] rise;
    logic [31:0] fall;
    logic [31:0] lvl_hit;
    logic [31:0] edge_hit;

    // edges compare with last sample; prev_valid blocks a false edge out of reset
    always_comb begin
        rise = tif.pins & ~s_q.prev & {32{s_q.prev_valid}};
        fall = ~tif.pins & s_q.prev & {32{s_q.prev_valid}};
        lvl_hit = ~(tif.pins ^ tif.sense);
        edge_hit = (tif.sense & rise) | (~tif.sense & fall);
        s_d = s_q;
        s_d.prev = tif.pins;
        s_d.prev_valid = 1'b1;
    end

    // each bit i uses only pin i; disabled pins never fire
    assign tif.fire = tif.allow & ((tif.kind & edge_hit) | (~tif.kind & lvl_hit));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    AST_RISE_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && $past(ce) && s_q.prev_valid) |->
        ((tif.fire & tif.kind & tif.sense) ==
         (tif.allow & tif.kind & tif.sense & tif.pins & ~$past(tif.pins))))
        else $error("rising edge trigger mismatch");
    AST_LEVEL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        ((tif.fire & ~tif.kind) == (tif.allow & ~tif.kind & ~(tif.pins ^ tif.sense))))
        else $error("level trigger mismatch");
endmodule : pio_trig

// File: rtl/pio_top.sv
/*
 * parallel io port with per-pin interrupt triggers and an axi-lite slave.
 * assumes a single aclk domain; input pins may be asynchronous.
 */
`timescale 1ns/1ps
module pio_top
    import pio_pkg::*;
#(
    parameter int unsigned PIN_COUNT = PIO_MAX_PINS // implemented pairs, 0..32
)(
    input wire logic aclk, // processor clock, 250 mhz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic [31:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [31:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [31:0] pin_in, // parallel input pins
    output logic [31:0] pin_out, // parallel output pins
    output logic fast_interrupt_line, // high while any pin flag is pending
    output logic irq // level interrupt from masked event status
);
    // unused upper bits are tied off through this mask; zero pins removes everything
    localparam logic [31:0] PIN_MASK = pio_pin_mask(PIN_COUNT);

    typedef struct packed {
        logic [31:0] out_q;
        logic [31:0] kind;
        logic [31:0] sense;
        logic [31:0] allow;
        logic [31:0] flags;
        logic [PIO_EVT_W-1:0] evt_status;
        logic [PIO_EVT_W-1:0] evt_mask;
        logic aw_held;
        logic [31:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        pio_rd_e rd_state;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pio_top_s;

    localparam pio_top_s TOP_RESET = '{
        out_q: PIO_REG_RESET,
        kind: PIO_REG_RESET,
        sense: PIO_REG_RESET,
        allow: PIO_REG_RESET,
        flags: PIO_REG_RESET,
        evt_status: PIO_EVT_RESET,
        evt_mask: PIO_EVT_RESET,
        rd_state: PIO_RD_IDLE,
        default: '0
    };

    pio_top_s s_q;
    pio_top_s s_d;
    logic [31:0] sync_pins;
    logic [31:0] fire_m;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    logic [31:0] keep_flags;
    logic [PIO_EVT_W-1:0] evt_set;
    logic [PIO_EVT_W-1:0] evt_clr;

    pio_trig_if tif();

    // input pins are asynchronous, so two flops before anything looks at them
    pio_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .async_in(pin_in),
        .sync_out(sync_pins)
    );

    pio_trig u_trig (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tif(tif)
    );

    // configuration to the detector, unused pins ignored
    assign tif.pins = sync_pins & PIN_MASK;
    assign tif.kind = s_q.kind;
    assign tif.sense = s_q.sense;
    assign tif.allow = s_q.allow;
    assign fire_m = tif.fire & PIN_MASK;

    // handshakes: one write and one read in flight; ce low stalls the bus
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign s_axi_awready = ce && !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready = ce && !s_q.w_held && !s_q.bvalid;
    assign s_axi_arready = ce && (s_q.rd_state == PIO_RD_IDLE);

    // read decode; reserved words answer okay with zero
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            PIO_ADDR_INPUT: rd_word = sync_pins & PIN_MASK;
            PIO_ADDR_OUTPUT: rd_word = s_q.out_q;
            PIO_ADDR_RSVD_A: rd_word = '0;
            PIO_ADDR_RSVD_B: rd_word = '0;
            PIO_ADDR_KIND: rd_word = s_q.kind;
            PIO_ADDR_SENSE: rd_word = s_q.sense;
            PIO_ADDR_ALLOW: rd_word = s_q.allow;
            PIO_ADDR_FLAGS: rd_word = s_q.flags;
            PIO_ADDR_EVT_STATUS: rd_word = {{(32-PIO_EVT_W){1'b0}}, s_q.evt_status};
            PIO_ADDR_EVT_MASK: rd_word = {{(32-PIO_EVT_W){1'b0}}, s_q.evt_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // write decode: read-only words take the write silently
    always_comb begin
        unique case (s_q.awaddr)
            PIO_ADDR_INPUT, PIO_ADDR_OUTPUT, PIO_ADDR_RSVD_A, PIO_ADDR_RSVD_B,
            PIO_ADDR_KIND, PIO_ADDR_SENSE, PIO_ADDR_ALLOW, PIO_ADDR_FLAGS,
            PIO_ADDR_EVT_STATUS, PIO_ADDR_EVT_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // strobed bytes keep only flags written as one, other bytes keep all
    assign keep_flags = pio_merge(PIO_ALL_ONES, s_q.wdata, s_q.wstrb);

    // events: any pin trigger fired, any access to an unmapped word
    always_comb begin
        evt_set = '0;
        evt_set[PIO_EVT_PIN] = |fire_m;
        evt_set[PIO_EVT_BUSERR] = (do_write && !wr_hit) || (ar_take && !rd_hit);
        evt_clr = '0;
        if (ar_take && s_axi_araddr == PIO_ADDR_EVT_STATUS) evt_clr = '1;
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        if (aw_take) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (w_take) begin
            s_d.w_held = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_hit ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
            unique case (s_q.awaddr)
                PIO_ADDR_OUTPUT:
                    s_d.out_q = pio_merge(s_q.out_q, s_q.wdata, s_q.wstrb) & PIN_MASK;
                PIO_ADDR_KIND:
                    s_d.kind = pio_merge(s_q.kind, s_q.wdata, s_q.wstrb) & PIN_MASK;
                PIO_ADDR_SENSE:
                    s_d.sense = pio_merge(s_q.sense, s_q.wdata, s_q.wstrb) & PIN_MASK;
                PIO_ADDR_ALLOW:
                    s_d.allow = pio_merge(s_q.allow, s_q.wdata, s_q.wstrb) & PIN_MASK;
                PIO_ADDR_EVT_MASK: begin
                    s_d.evt_mask = s_q.wdata[PIO_EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end else if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // a trigger in the clearing cycle still wins; level triggers re-set each clock
        if (do_write && s_q.awaddr == PIO_ADDR_FLAGS) begin
            s_d.flags = ((s_q.flags & keep_flags) | fire_m) & PIN_MASK;
        end else begin
            s_d.flags = (s_q.flags | fire_m) & PIN_MASK;
        end
        // set beats the read-clear
        s_d.evt_status = (s_q.evt_status & ~evt_clr) | evt_set;
        unique case (s_q.rd_state)
            PIO_RD_IDLE: begin
                if (ar_take) begin
                    s_d.rd_state = PIO_RD_RESP;
                    s_d.rdata = rd_word;
                    s_d.rresp = rd_hit ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
                end
            end
            PIO_RD_RESP: begin
                if (s_axi_rready) s_d.rd_state = PIO_RD_IDLE;
            end
            default: s_d.rd_state = PIO_RD_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= TOP_RESET;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops, apart from the two interrupt reductions, the rvalid state decode and the three ready signals gated by ce above
    assign pin_out = s_q.out_q;
    assign fast_interrupt_line = |s_q.flags;
    assign irq = |(s_q.evt_status & s_q.evt_mask);
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = (s_q.rd_state == PIO_RD_RESP);
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // checks on the register side
    sequence seq_out_write;
        ce && do_write && s_q.awaddr == PIO_ADDR_OUTPUT && s_q.wstrb == 4'hf;
    endsequence
    sequence seq_flag_clear;
        ce && do_write && s_q.awaddr == PIO_ADDR_FLAGS && s_q.wstrb == 4'hf && fire_m == '0;
    endsequence
    sequence seq_read_at(logic [31:0] a);
        ce && ar_take && s_axi_araddr == a;
    endsequence

    AST_OUT_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_out_write |=> (pin_out == ($past(s_q.wdata) & PIN_MASK)))
        else $error("output pins do not follow written value");
    AST_IN_READ: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_read_at(PIO_ADDR_INPUT) |=> s_axi_rvalid && (s_axi_rdata == ($past(sync_pins) & PIN_MASK)))
        else $error("input read does not show pins");
    AST_UNUSED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        ((pin_out | s_q.flags | s_q.kind | s_q.allow) & ~PIN_MASK) == '0)
        else $error("unused pin bits not zero");
    AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        (seq_read_at(PIO_ADDR_RSVD_A) or seq_read_at(PIO_ADDR_RSVD_B))
        |=> s_axi_rdata == '0 && s_axi_rresp == PIO_RESP_OKAY)
        else $error("reserved word not zero");
    AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && fire_m != '0) |=> ((s_q.flags & $past(fire_m)) == $past(fire_m)) && fast_interrupt_line)
        else $error("fired trigger did not set its flag");
    AST_FLAG_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_flag_clear |=> s_q.flags == ($past(s_q.flags) & $past(s_q.wdata)))
        else $error("flag clear wrong");
    AST_FAST_INTERRUPT_LINE_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_q.flags == '0) |-> !fast_interrupt_line)
        else $error("fast interrupt without flag");
    AST_BRESP_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && do_write) |=> s_axi_bvalid)
        else $error("write response missing");
endmodule : pio_top

// File: test/pio_pin_model.sv
/*
 * model of the pin-side partner: whatever drives the parallel input pins.
 * assumes the bench commands pin levels; the pins are always driven, never released.
 */
`timescale 1ns/1ps
module pio_pin_model (
    input wire logic aclk, // processor clock
    input wire logic [31:0] level, // levels commanded by the bench
    output logic [31:0] pin_in // pins as the block sees them
);
    // pins move a little after the edge, as an unrelated source would
    initial pin_in = 32'h00000000;
    always @(posedge aclk) begin
        pin_in <= #1 level;
    end
endmodule : pio_pin_model

// File: test/tb_parallel_io_port_with_pin_irq.sv
/*
 * self-checking bench for the parallel io port, driving its axi-lite slave.
 * assumes 8 implemented pin pairs and a pin model on the input side.
 */
`timescale 1ns/1ps
module tb_parallel_io_port_with_pin_irq;
    import pio_pkg::*;
    localparam int unsigned PINS = 8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr, wdata, araddr, rdata, pin_level, pin_in, pin_out;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, fli, irq;
    logic [1:0] bresp, rresp;
    int num_errors = 0;
    int compares = 0;

    // 250 mhz processor clock
    always #2 aclk = ~aclk;

    pio_top #(.PIN_COUNT(PINS)) u_pio_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
        .fast_interrupt_line(fli), .irq(irq));

    pio_pin_model u_pio_pin_model (.aclk(aclk), .level(pin_level), .pin_in(pin_in));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // address and data go out together; each is dropped once its ready is seen
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no local limit: a hung write is ended by the watchdog
        forever begin
            @(posedge aclk);
            if (aw_ok && w_ok && bvalid) break;
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        // bready stays high, so back-to-back writes never drop and raise it in one step
        check("bresp", {30'h0, bresp}, {30'h0, exp_resp});
    endtask : wr

    // read one word; rready is raised at the start and left high afterwards
    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
        logic ar_ok;
        ar_ok = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // no local limit: a hung read is ended by the watchdog
        forever begin
            @(posedge aclk);
            if (ar_ok && rvalid) break;
            if (!ar_ok && arready) begin
                ar_ok = 1'b1;
                arvalid <= 1'b0;
            end
        end
        check(name, rdata, exp);
        check("rresp", {30'h0, rresp}, {30'h0, exp_resp});
    endtask : rd_chk

    // a hang must still end with a verdict
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        complete_run();
    end

    // main sequence
    initial begin
        logic [31:0] cfg [4];
        cfg = '{PIO_ADDR_KIND, PIO_ADDR_SENSE, PIO_ADDR_ALLOW, PIO_ADDR_OUTPUT};
        {awaddr, wdata, araddr} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h0;
        pin_level = 32'hffffff05;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("pin_out_rst", pin_out, 32'h0);
        // reset zero, then only the low PINS bits hold a one
        foreach (cfg[i]) begin
            rd_chk("cfg_rst", cfg[i], PIO_REG_RESET, PIO_RESP_OKAY);
            wr(cfg[i], PIO_ALL_ONES, PIO_RESP_OKAY);
            rd_chk("cfg_ones", cfg[i], 32'h000000ff, PIO_RESP_OKAY);
        end
        check("pin_out_ones", pin_out, 32'h000000ff);
        wr(PIO_ADDR_OUTPUT, 32'h0000005a, PIO_RESP_OKAY);
        check("pin_out", pin_out, 32'h0000005a);
        wr(PIO_ADDR_RSVD_A, PIO_ALL_ONES, PIO_RESP_OKAY);
        wr(PIO_ADDR_RSVD_B, PIO_ALL_ONES, PIO_RESP_OKAY);
        rd_chk("rsvd_a", PIO_ADDR_RSVD_A, 32'h0, PIO_RESP_OKAY);
        rd_chk("rsvd_b", PIO_ADDR_RSVD_B, 32'h0, PIO_RESP_OKAY);
        rd_chk("input", PIO_ADDR_INPUT, 32'h00000005, PIO_RESP_OKAY);
        rd_chk("unmapped", 32'hfffc0040, 32'h0, PIO_RESP_SLVERR);
        wr(PIO_ADDR_EVT_MASK, 32'h00000001, PIO_RESP_OKAY);
        // pin0 low level, pin1 high level, pin2 falling, pin3 rising
        wr(PIO_ADDR_KIND, 32'h0000000c, PIO_RESP_OKAY);
        wr(PIO_ADDR_SENSE, 32'h0000000a, PIO_RESP_OKAY);
        wr(PIO_ADDR_ALLOW, 32'h0, PIO_RESP_OKAY);
        wr(PIO_ADDR_FLAGS, 32'h0, PIO_RESP_OKAY);
        // pin levels change by non-blocking assignment so the pin model never races the bench
        pin_level <= 32'h0000000a;
        repeat (6) @(posedge aclk);
        rd_chk("flags_off", PIO_ADDR_FLAGS, 32'h0, PIO_RESP_OKAY);
        check("fli_off", {31'h0, fli}, 32'h0);
        pin_level <= 32'hffffff05;
        repeat (6) @(posedge aclk);
        wr(PIO_ADDR_ALLOW, 32'h0000000f, PIO_RESP_OKAY);
        pin_level <= 32'h0000000a;
        repeat (6) @(posedge aclk);
        rd_chk("flags_fire", PIO_ADDR_FLAGS, 32'h0000000f, PIO_RESP_OKAY);
        check("fli_on", {31'h0, fli}, 32'h1);
        check("irq_on", {31'h0, irq}, 32'h1);
        // edges in the other direction must not fire
        pin_level <= 32'h00000005;
        repeat (6) @(posedge aclk);
        wr(PIO_ADDR_FLAGS, 32'h0000000c, PIO_RESP_OKAY);
        rd_chk("flags_keep", PIO_ADDR_FLAGS, 32'h0000000c, PIO_RESP_OKAY);
        wr(PIO_ADDR_FLAGS, 32'h0, PIO_RESP_OKAY);
        rd_chk("flags_clr", PIO_ADDR_FLAGS, 32'h0, PIO_RESP_OKAY);
        check("fli_clr", {31'h0, fli}, 32'h0);
        rd_chk("evt", PIO_ADDR_EVT_STATUS, 32'h00000003, PIO_RESP_OKAY);
        rd_chk("evt_clr", PIO_ADDR_EVT_STATUS, 32'h0, PIO_RESP_OKAY);
        check("irq_clr", {31'h0, irq}, 32'h0);
        // a held level refires after clearing
        pin_level <= 32'h00000007;
        repeat (6) @(posedge aclk);
        wr(PIO_ADDR_FLAGS, 32'h0, PIO_RESP_OKAY);
        rd_chk("flags_level", PIO_ADDR_FLAGS, 32'h00000002, PIO_RESP_OKAY);
        pin_level <= 32'h00000005;
        repeat (6) @(posedge aclk);
        wr(PIO_ADDR_EVT_MASK, 32'h0, PIO_RESP_OKAY);
        wr(32'hfffc0044, PIO_ALL_ONES, PIO_RESP_SLVERR);
        check("irq_masked", {31'h0, irq}, 32'h0);
        rd_chk("evt_both", PIO_ADDR_EVT_STATUS, 32'h00000003, PIO_RESP_OKAY);
        complete_run();
    end
endmodule : tb_parallel_io_port_with_pin_irq
